// File: hw/sel_link.sv
// serial link target of the secure element with frame and flow handling
`timescale 1ns/100ps
`include "sel_params.svh"

// What this block does
// - link runs clock polarity and phase mode 0
// - shifting runs on link clock, 1 Mbps and up
// - own select line frames transfers; answer only selected
// - full duplex: one bit each way per clock
// - link clock independent; words cross by toggles
// - built in target role on the link
// - target can request that host start a frame
// - suspend and resume keep all protocol state
// - payload delivered whole and in order
// - room advertised; refused payload dropped, and flagged only in frames begun from idle
// - transfer unit size given to upper layer
// - upper layer enables or disables the link
// - host activation and link events reported upward
module sel_link (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_link_clk,
   input wire logic i_cs_b,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_req_b,
   input wire logic i_enable,
   input wire logic i_suspend,
   input wire sel_pkg::sel_byte_t i_tx,
   output logic o_tx_ready,
   output sel_pkg::sel_byte_t o_rx,
   input wire logic i_rx_ready,
   output sel_pkg::sel_evt_t o_evt,
   output sel_pkg::sel_state_t o_state,
   output logic o_host_active,
   output logic [7:0] o_mtu
);

   // link clock domain
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [6:0] rx_sh;
   logic [6:0] next_rx_sh;
   logic [7:0] rx_hold;
   logic [7:0] next_rx_hold;
   logic [7:0] tx_cap;
   logic [7:0] next_tx_cap;
   logic rx_tgl;
   logic next_rx_tgl;
   logic tk_tgl;
   logic next_tk_tgl;
   logic miso_q;
   logic next_miso_q;
   logic started;

   // system clock domain
   logic [2:0] sync_q;
   logic cs_s;
   logic rxt_s;
   logic tkt_s;
   logic rxt_d;
   logic tkt_d;
   logic rx_ev;
   logic tk_ev;
   sel_pkg::sel_state_t state;
   sel_pkg::sel_state_t next_state;
   sel_pkg::sel_byte_t tx_buf;
   sel_pkg::sel_byte_t next_tx_buf;
   sel_pkg::sel_byte_t rx_q;
   sel_pkg::sel_byte_t next_rx_q;
   sel_pkg::sel_evt_t evt;
   sel_pkg::sel_evt_t next_evt;
   logic [7:0] tx_word;
   logic [7:0] next_tx_word;
   logic [7:0] ctl;
   logic [7:0] next_ctl;
   logic [7:0] status;
   logic [7:0] mtu;
   logic [1:0] bidx;
   logic [1:0] next_bidx;
   logic [1:0] tidx;
   logic [1:0] next_tidx;
   logic room_l;
   logic next_room_l;
   logic pay_l;
   logic next_pay_l;
   logic host_act;
   logic next_host_act;
   logic req_b;
   logic next_req_b;
   logic oe;
   logic next_oe;
   logic tx_rdy;
   logic next_tx_rdy;

   // ---------------- link side ----------------
   always_comb begin
      next_cnt = cnt + 3'h1;
      next_rx_sh = {rx_sh[5:0], i_mosi};
      next_rx_hold = rx_hold;
      next_rx_tgl = rx_tgl;
      next_tx_cap = tx_cap;
      next_tk_tgl = tk_tgl;
      if (cnt == `SEL_LAST_BIT) begin
         next_rx_hold = {rx_sh, i_mosi};
         next_rx_tgl = ~rx_tgl;
      end
      // while selected, tx_word is reloaded by the system side a few system clocks after each take, then held; between frames it tracks status
      if (cnt == `SEL_FIRST_BIT) begin
         next_tx_cap = tx_word;
         next_tk_tgl = ~tk_tgl;
      end
      // falling edge puts out the next bit of the byte in flight
      if (cnt == `SEL_FIRST_BIT) begin
         next_miso_q = tx_word[`SEL_MSB];
      end else begin
         next_miso_q = tx_cap[`SEL_LAST_BIT - cnt];
      end
   end

   // bit count restarts whenever select is released
   always_ff @(posedge i_link_clk or posedge i_cs_b) begin
      if (i_cs_b) begin
         cnt <= `SEL_FIRST_BIT;
      end else begin
         cnt <= next_cnt;
      end
   end

   // sampling on the rising link clock edge
   always_ff @(posedge i_link_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_sh <= 7'h00;
         rx_hold <= `SEL_RST_BYTE;
         tx_cap <= `SEL_RST_BYTE;
         rx_tgl <= 1'b0;
         tk_tgl <= 1'b0;
      end else begin
         rx_sh <= next_rx_sh;
         rx_hold <= next_rx_hold;
         tx_cap <= next_tx_cap;
         rx_tgl <= next_rx_tgl;
         tk_tgl <= next_tk_tgl;
      end
   end

   // changing on the falling link clock edge
   always_ff @(negedge i_link_clk or posedge i_cs_b) begin
      if (i_cs_b) begin
         miso_q <= 1'b0;
         started <= 1'b0;
      end else begin
         miso_q <= next_miso_q;
         started <= 1'b1;
      end
   end

   // before the first falling edge the top bit of the first byte is already out
   assign o_miso = started ? miso_q : tx_word[`SEL_MSB];

   // ---------------- crossing ----------------
   sel_sync2 #(
      .W(3),
      .INIT(3'b001)
   ) u_sync (
      .i_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_d({tk_tgl, rx_tgl, i_cs_b}),
      .o_q(sync_q)
   );

   assign cs_s = sync_q[0];
   assign rxt_s = sync_q[1];
   assign tkt_s = sync_q[2];
   assign rx_ev = rxt_s ^ rxt_d;
   assign tk_ev = tkt_s ^ tkt_d;

   // ---------------- system side ----------------
   always_comb begin
      status = `SEL_RST_BYTE;
      status[`SEL_ST_ROOM] = (state == sel_pkg::ST_IDLE) && !rx_q.valid;
      status[`SEL_ST_PEND] = (state == sel_pkg::ST_IDLE) && tx_buf.valid;
      status[`SEL_ST_ACT] = host_act;
      status[`SEL_ST_SUSP] = (state == sel_pkg::ST_SUSP);
      status[`SEL_ST_EN] = i_enable;

      next_state = state;
      next_tx_buf = tx_buf;
      next_rx_q = rx_q;
      next_evt = '0;
      next_tx_word = tx_word;
      next_ctl = ctl;
      next_bidx = bidx;
      next_tidx = tidx;
      next_room_l = room_l;
      next_pay_l = pay_l;
      next_host_act = host_act;

      if (rx_q.valid && i_rx_ready) begin
         next_rx_q.valid = 1'b0;
      end
      if (i_tx.valid && tx_rdy) begin
         next_tx_buf = i_tx;
      end

      case (state)
         sel_pkg::ST_OFF: begin
            if (i_enable && cs_s) begin
               next_state = sel_pkg::ST_IDLE;
            end
         end
         sel_pkg::ST_IDLE: begin
            if (!i_enable) begin
               next_state = sel_pkg::ST_OFF;
            end else if (i_suspend) begin
               next_state = sel_pkg::ST_SUSP;
            end else if (!cs_s) begin
               next_state = sel_pkg::ST_FRAME;
            end
         end
         sel_pkg::ST_FRAME: begin
            // a suspend or disable waits for the frame to close
            if (cs_s) begin
               next_evt.frame_end = 1'b1;
               if (!i_enable) begin
                  next_state = sel_pkg::ST_OFF;
               end else if (i_suspend) begin
                  next_state = sel_pkg::ST_SUSP;
               end else begin
                  next_state = sel_pkg::ST_IDLE;
               end
            end
         end
         sel_pkg::ST_SUSP: begin
            if (!i_enable) begin
               next_state = sel_pkg::ST_OFF;
            end else if (!i_suspend && cs_s) begin
               next_state = sel_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = sel_pkg::ST_OFF;
         end
      endcase

      if (cs_s) begin
         // between frames: offer status, freeze what it promised at frame start
         next_tx_word = status;
         next_tidx = `SEL_IDX_CTL;
         next_bidx = `SEL_IDX_CTL;
         next_room_l = status[`SEL_ST_ROOM];
         next_pay_l = status[`SEL_ST_PEND];
      end else begin
         if (tk_ev) begin
            if (tidx == `SEL_IDX_CTL) begin
               next_tx_word = pay_l ? tx_buf.data : `SEL_FILL;
            end else begin
               next_tx_word = `SEL_FILL;
               // payload leaves the buffer only once its first bit is clocked
               if (tidx == `SEL_IDX_PAY && pay_l) begin
                  next_tx_buf.valid = 1'b0;
               end
            end
            if (tidx != `SEL_IDX_END) begin
               next_tidx = tidx + 2'h1;
            end
         end
         if (rx_ev) begin
            if (bidx == `SEL_IDX_CTL) begin
               next_ctl = rx_hold;
               if (state == sel_pkg::ST_FRAME) begin
                  if (rx_hold[`SEL_CT_ACT]) begin
                     next_host_act = 1'b1;
                     next_evt.host_act = 1'b1;
                  end else if (rx_hold[`SEL_CT_DEACT]) begin
                     next_host_act = 1'b0;
                     next_evt.host_deact = 1'b1;
                  end
               end
            end else if (bidx == `SEL_IDX_PAY && ctl[`SEL_CT_VALID]
                         && state == sel_pkg::ST_FRAME) begin
               if (room_l) begin
                  next_rx_q.valid = 1'b1;
                  next_rx_q.data = rx_hold;
               end else begin
                  next_evt.overrun = 1'b1;
               end
            end
            if (bidx != `SEL_IDX_END) begin
               next_bidx = bidx + 2'h1;
            end
         end
      end

      next_tx_rdy = !next_tx_buf.valid;

      // request stays low from pending data until the host selects us or the link goes off
      if (!cs_s || state == sel_pkg::ST_OFF) begin
         next_req_b = 1'b1;
      end else if (state == sel_pkg::ST_IDLE && tx_buf.valid) begin
         next_req_b = 1'b0;
      end else begin
         next_req_b = req_b;
      end

      next_oe = !cs_s && i_enable && state != sel_pkg::ST_OFF;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         state <= sel_pkg::ST_OFF;
         tx_buf <= '0;
         rx_q <= '0;
         evt <= '0;
         tx_word <= `SEL_RST_BYTE;
         ctl <= `SEL_RST_BYTE;
         bidx <= `SEL_IDX_CTL;
         tidx <= `SEL_IDX_CTL;
         room_l <= 1'b0;
         pay_l <= 1'b0;
         host_act <= 1'b0;
         req_b <= 1'b1;
         oe <= 1'b0;
         tx_rdy <= 1'b1;
         rxt_d <= 1'b0;
         tkt_d <= 1'b0;
         mtu <= `SEL_MTU;
      end else if (i_ce) begin
         state <= next_state;
         tx_buf <= next_tx_buf;
         rx_q <= next_rx_q;
         evt <= next_evt;
         tx_word <= next_tx_word;
         ctl <= next_ctl;
         bidx <= next_bidx;
         tidx <= next_tidx;
         room_l <= next_room_l;
         pay_l <= next_pay_l;
         host_act <= next_host_act;
         req_b <= next_req_b;
         oe <= next_oe;
         tx_rdy <= next_tx_rdy;
         rxt_d <= rxt_s;
         tkt_d <= tkt_s;
         mtu <= `SEL_MTU;
      end
   end

   assign o_miso_oe = oe;
   assign o_req_b = req_b;
   assign o_tx_ready = tx_rdy;
   assign o_rx = rx_q;
   assign o_evt = evt;
   assign o_state = state;
   assign o_host_active = host_act;
   assign o_mtu = mtu;

   // ---------------- checks ----------------
   req_release_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      !cs_s |=> o_req_b)
      else $error("request still low while selected");

   req_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (cs_s && state == sel_pkg::ST_IDLE && tx_buf.valid) |=> !o_req_b)
      else $error("pending data raised no request");

   drive_sel_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      cs_s |=> !o_miso_oe)
      else $error("data pin driven while deselected");

   rx_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (o_rx.valid && !i_rx_ready) |=> (o_rx.valid && $stable(o_rx.data)))
      else $error("undelivered byte lost or changed");

   rx_deliver_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (rx_ev && !cs_s && bidx == `SEL_IDX_PAY && ctl[`SEL_CT_VALID] && room_l
       && state == sel_pkg::ST_FRAME) |=> (o_rx.valid && o_rx.data == $past(rx_hold)))
      else $error("payload byte not delivered");

   rx_overrun_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (rx_ev && !cs_s && bidx == `SEL_IDX_PAY && ctl[`SEL_CT_VALID] && !room_l
       && state == sel_pkg::ST_FRAME) |=> (o_evt.overrun && $stable(o_rx.data)))
      else $error("refused payload not flagged");

   mtu_out_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      1'b1 |-> ##1 o_mtu == `SEL_MTU)
      else $error("transfer unit size wrong");

   susp_keep_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (state == sel_pkg::ST_SUSP && i_suspend && i_enable)
      |=> (state == sel_pkg::ST_SUSP && $stable(o_host_active) && !status[`SEL_ST_ROOM]))
      else $error("suspend not held");

   off_state_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (!i_enable && state != sel_pkg::ST_FRAME) |=> state == sel_pkg::ST_OFF)
      else $error("link not disabled");

   host_act_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b || !i_ce)
      (rx_ev && !cs_s && bidx == `SEL_IDX_CTL && state == sel_pkg::ST_FRAME
       && rx_hold[`SEL_CT_ACT]) |=> (o_evt.host_act && o_host_active))
      else $error("host activation not reported");

endmodule

// File: hw/sel_params.svh
// constants of the secure element serial link
`ifndef SEL_PARAMS_SVH
`define SEL_PARAMS_SVH

// transfer unit reported to the layer above, in payload bytes per frame
`define SEL_MTU 8'h01
`define SEL_FILL 8'h00
`define SEL_RST_BYTE 8'h00

// bit counter positions inside a byte
`define SEL_FIRST_BIT 3'h0
`define SEL_LAST_BIT 3'h7
`define SEL_MSB 7

// byte index inside a frame
`define SEL_IDX_CTL 2'h0
`define SEL_IDX_PAY 2'h1
`define SEL_IDX_END 2'h2

// status byte sent by the device as byte 0 of each frame
`define SEL_ST_ROOM 0
`define SEL_ST_PEND 1
`define SEL_ST_ACT 2
`define SEL_ST_SUSP 3
`define SEL_ST_EN 4

// control byte sent by the host as byte 0 of each frame
`define SEL_CT_VALID 0
`define SEL_CT_DEACT 6
`define SEL_CT_ACT 7

`endif

// File: hw/sel_pkg.sv
// types of the secure element serial link
package sel_pkg;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sel_byte_t;

   typedef struct packed {
      logic host_act;
      logic host_deact;
      logic frame_end;
      logic overrun;
   } sel_evt_t;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_IDLE = 2'b01,
      ST_FRAME = 2'b11,
      ST_SUSP = 2'b10
   } sel_state_t;

endpackage

// File: hw/sel_sync2.sv
// two flip-flop synchroniser for single-bit levels and toggles
`timescale 1ns/100ps

module sel_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = i_d;
      next_q = meta;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta <= INIT;
         o_q <= INIT;
      end else if (i_ce) begin
         meta <= next_meta;
         o_q <= next_q;
      end
   end

endmodule

// File: verif/sel_host_model.sv
// host controller model that frames transfers on the serial link
`timescale 1ns/100ps

module sel_host_model (
   output logic o_link_clk,
   output logic o_cs_b,
   output logic o_mosi,
   input wire logic i_miso,
   input wire logic i_miso_oe
);
   initial begin
      o_link_clk = 1'b0;
      o_cs_b = 1'b0;
      o_mosi = 1'b0;
      // a clean rising select clears the link-side bit counter and data flop
      #1;
      o_cs_b = 1'b1;
   end

   // one frame: control and payload out, status and payload back, msb first
   task automatic xfer(input logic [7:0] ctl, input logic [7:0] pay, output logic [7:0] st,
         output logic [7:0] rx, output logic oe_seen);
      logic [15:0] tx;
      logic [15:0] got;
      tx = {ctl, pay};
      got = 16'h0000;
      // keeps link edges off the system clock grid
      #1.3;
      o_cs_b = 1'b0;
      o_mosi = tx[15];
      #80;
      oe_seen = i_miso_oe;
      for (int b = 15; b >= 0; b--) begin
         o_link_clk = 1'b1;
         got[b] = i_miso;
         #40;
         o_link_clk = 1'b0;
         if (b > 0) begin
            o_mosi = tx[b-1];
         end
         #40;
      end
      o_cs_b = 1'b1;
      // released line must not keep showing the last bit
      o_mosi = ~o_mosi;
      st = got[15:8];
      rx = got[7:0];
   endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench of the secure element serial link target
`timescale 1ns/100ps

module tb_top;
   logic i_sys_clk, i_rst_b, i_ce, i_enable, i_suspend, i_rx_ready, evt_clr;
   logic link_clk, cs_b, mosi, o_miso, o_miso_oe, o_req_b, o_tx_ready, o_host_active;
   sel_pkg::sel_byte_t i_tx;
   sel_pkg::sel_byte_t o_rx;
   sel_pkg::sel_evt_t o_evt;
   sel_pkg::sel_state_t o_state;
   logic [7:0] o_mtu;
   logic [3:0] evt_seen;
   logic [7:0] st, rx;
   logic oe;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int k;

   sel_link sel_link_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_link_clk(link_clk), .i_cs_b(cs_b), .i_mosi(mosi), .o_miso(o_miso),
      .o_miso_oe(o_miso_oe), .o_req_b(o_req_b), .i_enable(i_enable), .i_suspend(i_suspend),
      .i_tx(i_tx), .o_tx_ready(o_tx_ready), .o_rx(o_rx), .i_rx_ready(i_rx_ready),
      .o_evt(o_evt), .o_state(o_state), .o_host_active(o_host_active), .o_mtu(o_mtu));

   sel_host_model sel_host_model_i (.o_link_clk(link_clk), .o_cs_b(cs_b), .o_mosi(mosi),
      .i_miso(o_miso), .i_miso_oe(o_miso_oe));

   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   // one-cycle event pulses are kept until the next frame starts
   always @(posedge i_sys_clk) begin
      evt_seen <= evt_clr ? 4'h0 : (evt_seen | o_evt);
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   task automatic frame(input logic [7:0] ctl, input logic [7:0] pay);
      @(posedge i_sys_clk) evt_clr <= 1'b1;
      @(posedge i_sys_clk) evt_clr <= 1'b0;
      sel_host_model_i.xfer(ctl, pay, st, rx, oe);
      tick(12);
   endtask

   task automatic take_rx();
      @(posedge i_sys_clk) i_rx_ready <= 1'b1;
      @(posedge i_sys_clk) i_rx_ready <= 1'b0;
      tick(2);
      chk("rx valid after take", 8'h00, {7'h00, o_rx.valid});
   endtask

   task automatic t_reset();
      chk("state", 8'h00, {6'h00, o_state});
      chk("oe", 8'h00, {7'h00, o_miso_oe});
      chk("req", 8'h01, {7'h00, o_req_b});
      chk("tx ready", 8'h01, {7'h00, o_tx_ready});
      chk("rx valid", 8'h00, {7'h00, o_rx.valid});
      chk("mtu", 8'h01, o_mtu);
      frame(8'h81, 8'h11);
      chk("oe while off", 8'h00, {7'h00, oe});
      chk("rx while off", 8'h00, {7'h00, o_rx.valid});
      @(posedge i_sys_clk) i_enable <= 1'b1;
      tick(4);
      chk("state on", 8'h01, {6'h00, o_state});
   endtask

   task automatic t_activate();
      frame(8'h81, 8'ha5);
      chk("oe", 8'h01, {7'h00, oe});
      chk("status", 8'h11, st);
      chk("rx valid", 8'h01, {7'h00, o_rx.valid});
      chk("rx data", 8'ha5, o_rx.data);
      chk("host active", 8'h01, {7'h00, o_host_active});
      chk("act event", 8'h01, {7'h00, evt_seen[3]});
      chk("end event", 8'h01, {7'h00, evt_seen[1]});
   endtask

   task automatic t_flow();
      frame(8'h01, 8'h5a);
      chk("status full", 8'h14, st);
      chk("overrun event", 8'h01, {7'h00, evt_seen[0]});
      chk("rx kept", 8'ha5, o_rx.data);
      take_rx();
      frame(8'h01, 8'h5a);
      chk("status room", 8'h15, st);
      chk("rx next", 8'h5a, o_rx.data);
      take_rx();
   endtask

   task automatic t_request();
      @(posedge i_sys_clk) i_tx <= {1'b1, 8'h3c};
      @(posedge i_sys_clk) i_tx <= 9'h000;
      tick(1);
      chk("tx ready taken", 8'h00, {7'h00, o_tx_ready});
      for (k = 0; k < 50 && o_req_b !== 1'b0; k++) tick(1);
      chk("req raised", 8'h00, {7'h00, o_req_b});
      tick(30);
      chk("req held", 8'h00, {7'h00, o_req_b});
      // host answers the request by starting a frame
      frame(8'h00, 8'h00);
      chk("status pend", 8'h17, st);
      chk("tx byte", 8'h3c, rx);
      chk("req released", 8'h01, {7'h00, o_req_b});
      chk("tx ready again", 8'h01, {7'h00, o_tx_ready});
      chk("no stray rx", 8'h00, {7'h00, o_rx.valid});
   endtask

   // a low clock enable must hold off a suspend request until it rises again
   task automatic t_freeze();
      @(posedge i_sys_clk) i_ce <= 1'b0;
      @(posedge i_sys_clk) i_suspend <= 1'b1;
      tick(3);
      chk("state frozen", 8'h01, {6'h00, o_state});
      @(posedge i_sys_clk) i_ce <= 1'b1;
      tick(2);
      chk("state after freeze", 8'h02, {6'h00, o_state});
      @(posedge i_sys_clk) i_suspend <= 1'b0;
      tick(3);
      chk("state after thaw", 8'h01, {6'h00, o_state});
   endtask

   task automatic t_suspend();
      @(posedge i_sys_clk) i_suspend <= 1'b1;
      tick(3);
      chk("state susp", 8'h02, {6'h00, o_state});
      frame(8'h01, 8'h77);
      chk("status susp", 8'h1c, st);
      chk("rx in susp", 8'h00, {7'h00, o_rx.valid});
      @(posedge i_sys_clk) i_suspend <= 1'b0;
      tick(3);
      chk("state resumed", 8'h01, {6'h00, o_state});
      chk("active kept", 8'h01, {7'h00, o_host_active});
   endtask

   task automatic t_deact();
      frame(8'h40, 8'h00);
      chk("status", 8'h15, st);
      chk("host inactive", 8'h00, {7'h00, o_host_active});
      chk("deact event", 8'h01, {7'h00, evt_seen[2]});
      @(posedge i_sys_clk) i_enable <= 1'b0;
      tick(3);
      chk("state off", 8'h00, {6'h00, o_state});
   endtask

   task automatic report_and_stop();
      if (errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      i_rst_b = 1'b1;
      i_ce = 1'b1;
      i_enable = 1'b0;
      i_suspend = 1'b0;
      i_rx_ready = 1'b0;
      i_tx = 9'h000;
      evt_clr = 1'b1;
      // a clean falling reset edge clears the link-side shift, hold, capture and toggle registers
      @(posedge i_sys_clk) i_rst_b <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      tick(1);
      t_reset();
      t_activate();
      t_flow();
      t_request();
      t_freeze();
      t_suspend();
      t_deact();
      report_and_stop();
   end
endmodule
